// ---- shared/rsf_pkg.sv ----
// Constants, register map and types of the reset source and flag logic
`default_nettype none

package rsf_pkg;

	// Clock and timing
	localparam int CLK_NS           = 20;
	localparam int CLEAR_FILT_NS    = 100;
	localparam int CLEAR_FILT_CYC   = (CLEAR_FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int BROWNOUT_MIN_NS  = 200;
	localparam int BROWNOUT_MIN_CYC = (BROWNOUT_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int PWRT_US          = 64;
	localparam int PWRT_CYC         = (PWRT_US * 1000 + CLK_NS - 1) / CLK_NS;

	// Register offsets
	localparam logic [3:0] ADDR_RESET_CTRL = 4'h0;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h1;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
	localparam logic [3:0] ADDR_LAT_A    = 4'h3;
	localparam logic [3:0] ADDR_DIR_A    = 4'h4;
	localparam logic [3:0] ADDR_DIR_E    = 4'h5;
	localparam logic [3:0] ADDR_SER_CON1 = 4'h6;
	localparam logic [3:0] ADDR_SER_CON2 = 4'h7;
	localparam logic [3:0] ADDR_SER_STAT = 4'h8;
	localparam logic [3:0] ADDR_SER_ADDR = 4'h9;
	localparam logic [3:0] ADDR_SER_BUF  = 4'hA;
	localparam logic [3:0] ADDR_STATE    = 4'hB;

	// Reset control register fields
	localparam int RESET_CTRL_BROWNOUT_BIT = 0;
	localparam int RESET_CTRL_POWERON_BIT  = 1;

	// Interrupt status bits
	localparam int IRQ_CLEAR_PIN = 0;
	localparam int IRQ_BROWNOUT  = 1;
	localparam int IRQ_WDOG  = 2;
	localparam int IRQ_INSTR = 3;
	localparam int IRQ_STACK = 4;
	localparam int IRQ_CMIS  = 5;
	localparam int IRQ_WAKE  = 6;
	localparam int IRQ_W     = 7;

	// Reset values and implemented-bit masks
	localparam logic [7:0] ZERO8          = 8'h00;
	localparam logic [7:0] DIR_A_MASK     = 8'h2F;
	localparam logic [7:0] DIR_A_RESET    = 8'h2F;
	localparam logic [7:0] DIR_E_MASK     = 8'hF7;
	localparam logic [7:0] DIR_E_POR      = 8'h07;
	localparam logic [7:0] DIR_E_SOFT     = 8'hF7;
	localparam logic [7:0] LAT_A_MASK     = 8'h3F;
	// Synchroniser reset: master-clear bit idles high, the others low
	localparam logic [4:0] PIN_SYNC_IDLE  = 5'h01;

	typedef enum logic [1:0] {
		BO_IDLE,
		BO_RESET,
		BO_TIMER
	} rsf_bo_state_type;

endpackage

`default_nettype wire

// ---- core/rsf_reset_sequencer.sv ----
// Reset sources, reset-cause flags and per-reset register initialisation
//
// Function
// RQ1: Holding the master-clear pin low keeps the device in hard reset.
// RQ2: Low glitches on master clear shorter than the filter are ignored.
// RQ3: The master-clear pin is never driven low by the device.
// RQ4: Power-on reset clears the power-on flag; other resets leave it alone.
// RQ5: Only software sets the power-on flag back to one.
// RQ6: Brown-out detection works only while the regulator pin is tied high.
// RQ7: Supply below threshold for longer than minimum duration causes reset.
// RQ8: Brown-out reset holds while the supply stays below threshold.
// RQ9: After brown-out ends, the power-up timer extends the reset.
// RQ10: A dip during the power-up timer re-enters brown-out and restarts it.
// RQ11: Brown-out and power-on resets clear the brown-out flag.
// RQ12: Software reads flag zero with power-on flag one as a brown-out.
// RQ13: The low-voltage variant has brown-out reset disabled entirely.
// RQ14: Without brown-out detection, power-on still clears the brown-out flag.
// RQ15: Configuration bit routes capture unit two to default or alternate pin.
// RQ16: Power-on or brown-out sets directions, zeroes serial-two control registers.
// RQ17: Other hard resets keep latches, set directions, zero serial-two controls.
// RQ18: Wake-up from sleep leaves all listed registers unchanged.
// RQ19: All sources merge into one reset, async assert, sync release.
`timescale 1ns/1ps
`default_nettype none

module rsf_reset_sequencer
	import rsf_pkg::*;
#(
	parameter int CLEAR_FILTER_CYCLES = CLEAR_FILT_CYC,
	parameter int BROWNOUT_MIN_CYCLES = BROWNOUT_MIN_CYC,
	parameter int PWRT_CYCLES        = PWRT_CYC,
	parameter bit BROWNOUT_PRESENT   = 1'b1
) (
	// Clock and power-on reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// Master-clear pin
	input  wire logic        master_clear_pin_in,
	output logic             master_clear_pin_out,
	output logic             master_clear_pin_oe,
	// Supply monitor
	input  wire logic        regulator_enable_pin,
	input  wire logic        supply_below_threshold,
	// Internal reset and wake sources
	input  wire logic        watchdog_timer_reset,
	input  wire logic        reset_instruction,
	input  wire logic        stack_reset,
	input  wire logic        config_mismatch_reset,
	input  wire logic        wake_event,
	// Capture unit two routing
	input  wire logic        capture_two_pin_select,
	input  wire logic        capture_two_out,
	input  wire logic        capture_two_default_pin_in,
	input  wire logic        capture_two_alt_pin_in,
	output logic             capture_two_default_pin_out,
	output logic             capture_two_alt_pin_out,
	output logic             capture_two_in,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [7:0]  reg_rdata,
	// Results
	output logic             core_reset_n,
	output logic             irq,
	output logic      [7:0]  port_a_output_latch,
	output logic      [7:0]  port_a_direction,
	output logic      [7:0]  port_e_direction
);

	localparam int CW = $clog2(PWRT_CYCLES + BROWNOUT_MIN_CYCLES + 1);
	localparam int FW = $clog2(CLEAR_FILTER_CYCLES + 1);
	localparam int SW = 5;

	// Pin synchronisers: first stage is read only by the second
	logic [SW-1:0]      pin_meta_reg;
	logic [SW-1:0]      pin_sync_reg;
	logic               clear_pin_high;
	logic               below;
	logic               regen;
	logic               cap_def_s;
	logic               cap_alt_s;

	logic [FW-1:0]      clear_cnt_reg;
	logic               clear_active_reg;
	rsf_bo_state_type   bo_state_reg;
	rsf_bo_state_type   bo_state_next;
	logic [CW-1:0]      bo_cnt_reg;
	logic [CW-1:0]      bo_cnt_next;
	logic               brownout_en;
	logic               brownout_enter;
	logic               soft_src;
	logic               soft_init;
	logic               hard_init;
	logic               hard_reset_reg;
	logic               rst_clr_n;
	logic               core_meta_reg;
	logic               por_flag_reg;
	logic               brownout_flag_reg;
	logic [IRQ_W-1:0]   irq_stat_reg;
	logic [IRQ_W-1:0]   irq_mask_reg;
	logic [IRQ_W-1:0]   irq_set;
	logic [7:0]         ser_con1_reg;
	logic [7:0]         ser_con2_reg;
	logic [7:0]         ser_stat_reg;
	logic [7:0]         ser_addr_reg;
	logic [7:0]         ser_buf_reg;
	logic [7:0]         rdata_next;

	function automatic logic wr_hit(input logic [3:0] a);
		wr_hit = reg_write && (reg_addr == a);
	endfunction

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			// Idle levels, so leaving reset does not look like a press
			pin_meta_reg <= PIN_SYNC_IDLE;
			pin_sync_reg <= PIN_SYNC_IDLE;
		end else begin
			pin_meta_reg <= {capture_two_alt_pin_in, capture_two_default_pin_in,
				regulator_enable_pin, supply_below_threshold, master_clear_pin_in};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	assign clear_pin_high = pin_sync_reg[0];
	assign below     = pin_sync_reg[1];
	assign regen     = pin_sync_reg[2];
	assign cap_def_s = pin_sync_reg[3];
	assign cap_alt_s = pin_sync_reg[4];

	// RQ3: never drive pin
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			master_clear_pin_out <= 1'b0;
			master_clear_pin_oe  <= 1'b0;
		end else begin
			master_clear_pin_out <= 1'b0;
			master_clear_pin_oe  <= 1'b0;
		end
	end

	// RQ2: glitch filter count
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			clear_cnt_reg <= '0;
		end else if (clear_pin_high) begin
			clear_cnt_reg <= '0;
		end else if (clear_cnt_reg != FW'(CLEAR_FILTER_CYCLES)) begin
			clear_cnt_reg <= clear_cnt_reg + FW'(1);
		end
	end

	// RQ1: reset while pin held low
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			clear_active_reg <= 1'b0;
		end else if (clear_pin_high) begin
			clear_active_reg <= 1'b0;
		end else if (clear_cnt_reg == FW'(CLEAR_FILTER_CYCLES - 1)) begin
			clear_active_reg <= 1'b1;
		end
	end

	// RQ6: regulator gates detection
	// RQ13: variant without detector
	assign brownout_en = BROWNOUT_PRESENT && regen;

	always_comb begin
		bo_state_next = bo_state_reg;
		bo_cnt_next   = bo_cnt_reg;
		unique case (bo_state_reg)
			BO_IDLE: begin
				// RQ7: dip longer than minimum
				if (brownout_en && below) begin
					if (bo_cnt_reg == CW'(BROWNOUT_MIN_CYCLES - 1)) begin
						bo_state_next = BO_RESET;
						bo_cnt_next   = '0;
					end else begin
						bo_cnt_next = bo_cnt_reg + CW'(1);
					end
				end else begin
					bo_cnt_next = '0;
				end
			end
			BO_RESET: begin
				bo_cnt_next = '0;
				// RQ8: hold while below
				if (!brownout_en) begin
					bo_state_next = BO_IDLE;
				end else if (!below) begin
					bo_state_next = BO_TIMER;
				end
			end
			BO_TIMER: begin
				// RQ10: dip restarts timer
				if (brownout_en && below) begin
					bo_state_next = BO_RESET;
					bo_cnt_next   = '0;
				// RQ9: power-up timer delay
				end else if (bo_cnt_reg == CW'(PWRT_CYCLES - 1)) begin
					bo_state_next = BO_IDLE;
					bo_cnt_next   = '0;
				end else begin
					bo_cnt_next = bo_cnt_reg + CW'(1);
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bo_state_reg <= BO_IDLE;
			bo_cnt_reg   <= '0;
		end else begin
			bo_state_reg <= bo_state_next;
			bo_cnt_reg   <= bo_cnt_next;
		end
	end

	assign brownout_enter = (bo_state_reg == BO_IDLE) && (bo_state_next == BO_RESET);
	assign hard_init      = brownout_enter || (bo_state_reg != BO_IDLE);
	assign soft_src       = watchdog_timer_reset || reset_instruction
		|| stack_reset || config_mismatch_reset;
	assign soft_init      = clear_active_reg || soft_src;

	// RQ19: merge all sources
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hard_reset_reg <= 1'b1;
		end else begin
			hard_reset_reg <= clear_active_reg || soft_src || hard_init;
		end
	end

	// Cleared by reset_n or a flop only, so the asynchronous assert path cannot glitch
	assign rst_clr_n = reset_n && !hard_reset_reg;

	// RQ19: async assert, sync release
	always_ff @(posedge mclk or negedge rst_clr_n) begin
		if (!rst_clr_n) begin
			core_meta_reg <= 1'b0;
			core_reset_n  <= 1'b0;
		end else begin
			core_meta_reg <= 1'b1;
			core_reset_n  <= core_meta_reg;
		end
	end

	// RQ4: cleared by power-on or a software write, not by other resets
	// RQ5: software sets it back
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			por_flag_reg <= 1'b0;
		end else if (wr_hit(ADDR_RESET_CTRL)) begin
			por_flag_reg <= reg_wdata[RESET_CTRL_POWERON_BIT];
		end
	end

	// RQ11: brown-out clears flag
	// RQ14: power-on clears flag
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			brownout_flag_reg <= 1'b0;
		end else if (hard_init) begin
			brownout_flag_reg <= 1'b0;
		end else if (wr_hit(ADDR_RESET_CTRL)) begin
			brownout_flag_reg <= reg_wdata[RESET_CTRL_BROWNOUT_BIT];
		end
	end

	always_comb begin
		irq_set                = '0;
		irq_set[IRQ_CLEAR_PIN] = clear_active_reg;
		irq_set[IRQ_BROWNOUT]  = brownout_enter;
		irq_set[IRQ_WDOG]  = watchdog_timer_reset;
		irq_set[IRQ_INSTR] = reset_instruction;
		irq_set[IRQ_STACK] = stack_reset;
		irq_set[IRQ_CMIS]  = config_mismatch_reset;
		irq_set[IRQ_WAKE]  = wake_event;
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_reg <= '0;
		end else if (wr_hit(ADDR_IRQ_STAT)) begin
			irq_stat_reg <= (irq_stat_reg & ~reg_wdata[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_set;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_mask_reg <= '0;
		end else if (wr_hit(ADDR_IRQ_MASK)) begin
			irq_mask_reg <= reg_wdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// Latch content after power-on is undefined; zero is the cheapest choice
	// RQ17: latch kept on soft reset
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			port_a_output_latch <= ZERO8;
		end else if (!hard_init && !soft_init && wr_hit(ADDR_LAT_A)) begin
			port_a_output_latch <= reg_wdata & LAT_A_MASK;
		end
	end

	// RQ16: directions to ones
	// RQ17: directions to ones
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			port_a_direction <= DIR_A_RESET;
		end else if (hard_init || soft_init) begin
			port_a_direction <= DIR_A_RESET;
		end else if (wr_hit(ADDR_DIR_A)) begin
			port_a_direction <= reg_wdata & DIR_A_MASK;
		end
	end

	// RQ16: port E power-on value
	// RQ17: port E soft value
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			port_e_direction <= DIR_E_POR;
		end else if (hard_init) begin
			port_e_direction <= DIR_E_POR;
		end else if (soft_init) begin
			port_e_direction <= DIR_E_SOFT;
		end else if (wr_hit(ADDR_DIR_E)) begin
			port_e_direction <= reg_wdata & DIR_E_MASK;
		end
	end

	// RQ16: serial controls zeroed
	// RQ17: serial controls zeroed
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ser_con1_reg <= ZERO8;
			ser_con2_reg <= ZERO8;
			ser_stat_reg <= ZERO8;
			ser_addr_reg <= ZERO8;
		end else if (hard_init || soft_init) begin
			ser_con1_reg <= ZERO8;
			ser_con2_reg <= ZERO8;
			ser_stat_reg <= ZERO8;
			ser_addr_reg <= ZERO8;
		end else begin
			if (wr_hit(ADDR_SER_CON1)) begin
				ser_con1_reg <= reg_wdata;
			end
			if (wr_hit(ADDR_SER_CON2)) begin
				ser_con2_reg <= reg_wdata;
			end
			if (wr_hit(ADDR_SER_STAT)) begin
				ser_stat_reg <= reg_wdata;
			end
			if (wr_hit(ADDR_SER_ADDR)) begin
				ser_addr_reg <= reg_wdata;
			end
		end
	end

	// RQ17: buffer kept on soft reset
	// RQ18: wake changes nothing
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ser_buf_reg <= ZERO8;
		end else if (!hard_init && !soft_init && wr_hit(ADDR_SER_BUF)) begin
			ser_buf_reg <= reg_wdata;
		end
	end

	// RQ15: capture pin routing
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			capture_two_default_pin_out <= 1'b0;
			capture_two_alt_pin_out     <= 1'b0;
			capture_two_in              <= 1'b0;
		end else begin
			capture_two_default_pin_out <= capture_two_pin_select && capture_two_out;
			capture_two_alt_pin_out     <= !capture_two_pin_select && capture_two_out;
			capture_two_in              <= capture_two_pin_select ? cap_def_s : cap_alt_s;
		end
	end

	always_comb begin
		rdata_next = ZERO8;
		unique case (reg_addr)
			ADDR_RESET_CTRL: begin
				rdata_next[RESET_CTRL_POWERON_BIT]  = por_flag_reg;
				rdata_next[RESET_CTRL_BROWNOUT_BIT] = brownout_flag_reg;
			end
			ADDR_IRQ_STAT: rdata_next[IRQ_W-1:0] = irq_stat_reg;
			ADDR_IRQ_MASK: rdata_next[IRQ_W-1:0] = irq_mask_reg;
			ADDR_LAT_A:    rdata_next = port_a_output_latch;
			ADDR_DIR_A:    rdata_next = port_a_direction;
			ADDR_DIR_E:    rdata_next = port_e_direction;
			ADDR_SER_CON1: rdata_next = ser_con1_reg;
			ADDR_SER_CON2: rdata_next = ser_con2_reg;
			ADDR_SER_STAT: rdata_next = ser_stat_reg;
			ADDR_SER_ADDR: rdata_next = ser_addr_reg;
			ADDR_SER_BUF:  rdata_next = ser_buf_reg;
			ADDR_STATE: begin
				rdata_next[0] = clear_active_reg;
				rdata_next[1] = bo_state_reg == BO_RESET;
				rdata_next[2] = bo_state_reg == BO_TIMER;
				rdata_next[3] = brownout_en;
				rdata_next[4] = capture_two_pin_select;
			end
			default: rdata_next = ZERO8;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= ZERO8;
		end else if (reg_read) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= ZERO8;
		end
	end

endmodule

`default_nettype wire

// ---- test/rsf_board_model.sv ----
// Board side of the reset sequencer: master-clear pull-up, switch and supply comparator
`timescale 1ns/1ps
`default_nettype none

module rsf_board_model (
	// Commands from the bench
	input  wire logic hold_low,
	input  wire logic dip,
	// Device side of the master-clear pin
	input  wire logic pin_out,
	input  wire logic pin_oe,
	// Levels seen by the device
	output logic      master_clear_pin_in,
	output logic      supply_below_threshold
);
	// pin held low by the switch
	// Pull-up wins whenever neither party drives the pin low
	assign master_clear_pin_in = (hold_low || (pin_oe && !pin_out)) ? 1'h0 : 1'h1;
	assign supply_below_threshold = dip;
endmodule

`default_nettype wire

// ---- test/rsf_seq_assertions.sv ----
// Port-level checker of the reset sequencer
`timescale 1ns/1ps
`default_nettype none

module rsf_seq_assertions
	import rsf_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       reset_n,
	// Pins and sources
	input  wire logic       master_clear_pin_in,
	input  wire logic       master_clear_pin_out,
	input  wire logic       master_clear_pin_oe,
	input  wire logic       reset_instruction,
	input  wire logic       stack_reset,
	input  wire logic       watchdog_timer_reset,
	input  wire logic       wake_event,
	input  wire logic       capture_two_pin_select,
	input  wire logic       capture_two_out,
	input  wire logic       capture_two_default_pin_out,
	input  wire logic       capture_two_alt_pin_out,
	// Register port and results
	input  wire logic       reg_read,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       core_reset_n,
	input  wire logic [7:0] port_a_output_latch,
	input  wire logic [7:0] port_a_direction,
	input  wire logic [7:0] port_e_direction
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	chk_pin_not_driven: assert property (!master_clear_pin_oe && !master_clear_pin_out)
		else $error("master clear pin driven by device");
	chk_release_sync: assert property ($rose(reset_n) |-> !core_reset_n ##1 !core_reset_n)
		else $error("core reset released too early");
	chk_soft_reset_low: assert property (watchdog_timer_reset |-> ##[1:3] !core_reset_n)
		else $error("watchdog did not reset core");
	chk_soft_dirs: assert property (reset_instruction |=>
		port_a_direction == DIR_A_RESET && port_e_direction == DIR_E_SOFT)
		else $error("soft reset direction values wrong");
	chk_latch_kept: assert property (stack_reset |=>
		port_a_output_latch == $past(port_a_output_latch))
		else $error("latch changed by soft reset");
	chk_clear_glitch: assert property ((core_reset_n && master_clear_pin_in) ##1
		!master_clear_pin_in ##1 master_clear_pin_in |-> core_reset_n [*4])
		else $error("glitch on master clear reset device");
	chk_clear_held: assert property (!master_clear_pin_in [*8] |-> !core_reset_n)
		else $error("held master clear gave no reset");
	chk_capture_route: assert property ($past(reset_n) |->
		capture_two_default_pin_out == ($past(capture_two_pin_select) & $past(capture_two_out))
		&& capture_two_alt_pin_out == (!$past(capture_two_pin_select) & $past(capture_two_out)))
		else $error("capture two routed wrongly");
	chk_wake_keeps: assert property (wake_event |=>
		$stable(port_a_direction) && $stable(port_e_direction))
		else $error("wake changed directions");
	chk_rdata_stands: assert property (!$past(reg_read) |-> reg_rdata == ZERO8)
		else $error("read data outside its cycle");
endmodule

bind rsf_reset_sequencer rsf_seq_assertions u_chk (.mclk, .reset_n, .master_clear_pin_in,
	.master_clear_pin_out, .master_clear_pin_oe, .reset_instruction, .stack_reset,
	.watchdog_timer_reset, .wake_event, .capture_two_pin_select, .capture_two_out,
	.capture_two_default_pin_out, .capture_two_alt_pin_out, .reg_read, .reg_rdata,
	.core_reset_n, .port_a_output_latch, .port_a_direction, .port_e_direction);

`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench of the reset sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import rsf_pkg::*;
;
	localparam int PW = 20;
	logic       mclk = 1'h0, reset_n = 1'h0, hold = 1'h0, dip = 1'h0, wake_event = 1'h0;
	logic       regulator_enable_pin = 1'h0, capture_two_pin_select = 1'h0;
	logic       capture_two_out = 1'h0, capture_two_default_pin_in = 1'h0;
	logic       capture_two_alt_pin_in = 1'h0, reg_write = 1'h0, reg_read = 1'h0;
	logic [3:0] reg_addr = 4'h0, src = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, port_a_output_latch;
	logic [7:0] port_a_direction, port_e_direction;
	logic       watchdog_timer_reset, reset_instruction, stack_reset, config_mismatch_reset;
	logic       master_clear_pin_in, supply_below_threshold, master_clear_pin_out;
	logic       master_clear_pin_oe, capture_two_default_pin_out, capture_two_alt_pin_out;
	logic       capture_two_in, core_reset_n, irq;
	int         miscompares = 0, comparisons = 0, n;

	assign {config_mismatch_reset, stack_reset, reset_instruction, watchdog_timer_reset} = src;
	always #10 mclk = ~mclk;

	rsf_board_model board (.hold_low(hold), .dip, .pin_out(master_clear_pin_out),
		.pin_oe(master_clear_pin_oe), .master_clear_pin_in, .supply_below_threshold);

	rsf_reset_sequencer #(.CLEAR_FILTER_CYCLES(2), .BROWNOUT_MIN_CYCLES(3),
		.PWRT_CYCLES(PW)) DUT (
		.mclk, .reset_n, .master_clear_pin_in, .master_clear_pin_out, .master_clear_pin_oe,
		.regulator_enable_pin, .supply_below_threshold, .watchdog_timer_reset,
		.reset_instruction, .stack_reset, .config_mismatch_reset, .wake_event,
		.capture_two_pin_select, .capture_two_out, .capture_two_default_pin_in,
		.capture_two_alt_pin_in, .capture_two_default_pin_out, .capture_two_alt_pin_out,
		.capture_two_in, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.core_reset_n, .irq, .port_a_output_latch, .port_a_direction, .port_e_direction);

	task chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask

	task tick(input int k);
		repeat (k) @(posedge mclk);
	endtask

	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'h1;
		@(posedge mclk);
		reg_write <= 1'h0;
	endtask

	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge mclk);
		reg_read <= 1'h0;
		#1;
		chk(reg_rdata, e);
	endtask

	// Bounded wait for the merged reset to release, counting cycles
	task wait_rel(output int c);
		c = 0;
		while (core_reset_n !== 1'h1 && c < 200) begin
			@(posedge mclk);
			#1;
			c++;
		end
		if (c >= 200) chk(8'h00, 8'h01);
	endtask

	task test_done;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		tick(20);
		reset_n <= 1'h1;
		wait_rel(n);
		rd(ADDR_RESET_CTRL, 8'h00);
		chk(port_a_direction, DIR_A_RESET);
		chk(port_e_direction, DIR_E_POR);
		for (int a = 6; a < 10; a++) rd(a[3:0], 8'h00);
		rd(4'hC, 8'h00);
		wr(ADDR_RESET_CTRL, 8'h03);
		rd(ADDR_RESET_CTRL, 8'h03);
		wr(ADDR_LAT_A, 8'h15);
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_DIR_A, 8'h00);
			wr(ADDR_DIR_E, 8'h00);
			wr(ADDR_SER_CON1, 8'h5A);
			wr(ADDR_IRQ_STAT, 8'hFF);
			@(posedge mclk);
			if (i < 4) begin
				src[i] <= 1'h1;
				@(posedge mclk);
				src <= 4'h0;
				tick(3);
			end else begin
				hold <= 1'h1;
				tick(10);
				#1;
				chk({7'h00, core_reset_n}, 8'h00);
				@(posedge mclk);
				hold <= 1'h0;
			end
			wait_rel(n);
			chk(port_a_direction, DIR_A_RESET);
			chk(port_e_direction, DIR_E_SOFT);
			rd(ADDR_SER_CON1, 8'h00);
			rd(ADDR_LAT_A, 8'h15);
			rd(ADDR_RESET_CTRL, 8'h03);
			rd(ADDR_IRQ_STAT, (i < 4) ? 8'h04 << i : 8'h01);
		end
		wr(ADDR_IRQ_STAT, 8'hFF);
		@(posedge mclk);
		hold <= 1'h1;
		@(posedge mclk);
		hold <= 1'h0;
		tick(8);
		rd(ADDR_IRQ_STAT, 8'h00);
		@(posedge mclk);
		dip <= 1'h1;
		tick(20);
		#1;
		chk({7'h00, core_reset_n}, 8'h01);
		@(posedge mclk);
		dip <= 1'h0;
		regulator_enable_pin <= 1'h1;
		tick(4);
		dip <= 1'h1;
		tick(10);
		#1;
		chk({7'h00, core_reset_n}, 8'h00);
		@(posedge mclk);
		dip <= 1'h0;
		tick(8);
		#1;
		chk({7'h00, core_reset_n}, 8'h00);
		@(posedge mclk);
		dip <= 1'h1;
		tick(6);
		dip <= 1'h0;
		wait_rel(n);
		chk({7'h00, n >= PW && n <= PW + 8}, 8'h01);
		rd(ADDR_RESET_CTRL, 8'h02);
		chk(port_e_direction, DIR_E_POR);
		rd(ADDR_LAT_A, 8'h15);
		wr(ADDR_IRQ_MASK, 8'h02);
		tick(2);
		#1;
		chk({7'h00, irq}, 8'h01);
		wr(ADDR_IRQ_MASK, 8'h01);
		tick(2);
		#1;
		chk({7'h00, irq}, 8'h00);
		wr(ADDR_IRQ_STAT, 8'hFF);
		rd(ADDR_IRQ_STAT, 8'h00);
		wr(ADDR_DIR_A, 8'h00);
		@(posedge mclk);
		wake_event <= 1'h1;
		@(posedge mclk);
		wake_event <= 1'h0;
		tick(2);
		#1;
		chk(port_a_direction, 8'h00);
		rd(ADDR_IRQ_STAT, 8'h40);
		@(posedge mclk);
		capture_two_pin_select <= 1'h1;
		capture_two_out <= 1'h1;
		tick(3);
		#1;
		chk({6'h00, capture_two_default_pin_out, capture_two_alt_pin_out}, 8'h02);
		@(posedge mclk);
		capture_two_pin_select <= 1'h0;
		capture_two_alt_pin_in <= 1'h1;
		tick(4);
		#1;
		chk({6'h00, capture_two_default_pin_out, capture_two_alt_pin_out}, 8'h01);
		chk({7'h00, capture_two_in}, 8'h01);
		@(posedge mclk);
		reset_n <= 1'h0;
		tick(3);
		reset_n <= 1'h1;
		wait_rel(n);
		rd(ADDR_RESET_CTRL, 8'h00);
		test_done;
	end

	initial begin
		tick(5000);
		miscompares++;
		test_done;
	end
endmodule

`default_nettype wire
